// ### rtl/tbel_core.sv
// Touch event core: thresholds, compensation triggers, wake sequence and auto-lit mapping
`default_nettype none
`include "tbel_defines.svh"
// Notes on behaviour
// - Averaging stops for a sensor whose ticks reach four times the suspend threshold.
// - Three or more suspended sensors at once request offset compensation.
// - Samples below the negative threshold are counted; reaching the maximum requests compensation.
// - A compensation request holds until the front end reports fresh baseline values.
// - Touch when ticks exceed threshold plus threshold times common hysteresis percent.
// - Release when ticks drop below threshold minus threshold times hysteresis percent.
// - A nonzero stuck timeout, in seconds, forces a release while the finger stays.
// - After a forced release the real release must come before a new touch.
// - A zero stuck timeout disables the stuck timer.
// - Wake length bits 2:0; zero wakes on any event, one to six need keys.
// - Wake length seven: only the general input or a host command leaves doze.
// - A wake key counts only once its button is touched and then released.
// - Other events while a wake key is held are ignored by the tracker.
// - A wrong key discards progress; the sequence restarts from key zero.
// - Wake keys are 4-bit button codes, zero to seven; higher codes never match.
// - Each output has a 4-bit map: button, group zero or group one.
// - A button-mapped output turns on at touch and off at release.
// - A group event is any event of a button enabled in its membership mask.
module tbel_core #(
  parameter int TW = 16,
  parameter int CYCLES_PER_SECOND = `TBEL_SECOND_NS / `TBEL_CLOCK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic [7:0][TW-1:0] ticks,
  input wire logic [7:0][9:0] capacitance_threshold,
  input wire logic comp_done,
  input wire logic doze_enter,
  input wire logic general_input_wake,
  input wire logic host_wake_cmd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] avg_suspend,
  output logic comp_req,
  output logic doze,
  output logic [7:0] button_touched,
  output logic [7:0] auto_lit_output
);
  localparam logic [27:0] SEC_LAST = 28'(CYCLES_PER_SECOND - 1);

  tbel_pkg::tbel_core_reg_t q;
  tbel_pkg::tbel_core_reg_t d;
  logic [7:0] avg_hit;
  logic [7:0] neg_hit;
  logic [7:0] touch_ev;
  logic [7:0] release_ev;
  logic [7:0] led_nx;
  logic [3:0] hit_count;
  logic [7:0] neg_cnt_nx;
  logic neg_fire;
  logic three_fire;
  logic [2:0] first_touch;
  logic [3:0] want_key;
  logic key_match;
  logic final_key;

  generate
    if (CYCLES_PER_SECOND < 2 || CYCLES_PER_SECOND > 268_435_456) begin : g_bad_sec
      $error("cycles per second out of range");
    end
  endgenerate

  // ****************************************************************
  // Per-sensor compare, decision and output mapping
  // ****************************************************************
  generate
    for (genvar i = 0; i < 8; i++) begin : g_ch
      logic signed [TW+1:0] tick_x;
      logic signed [TW+1:0] avg_lvl;
      logic signed [TW+1:0] neg_lvl;
      logic [3:0] code;
      logic [7:0] sel;
      logic any_on;
      logic any_off;
      assign tick_x = (TW + 2)'($signed(ticks[i]));
      // Thresholds are coded in steps of four ticks
      assign avg_lvl = $signed((TW + 2)'({q.avg_thr, 2'b00}));
      assign neg_lvl = -$signed((TW + 2)'({q.neg_thr, 2'b00}));
      assign avg_hit[i] = tick_x >= avg_lvl;
      assign neg_hit[i] = tick_x < neg_lvl;

      tbel_btn #(
        .TW(TW)
      ) u_btn (
        .clock(clock),
        .rst(rst),
        .sample_valid(sample_valid),
        .ticks(ticks[i]),
        .capacitance_threshold(capacitance_threshold[i]),
        .touch_hysteresis_percent(q.hyst),
        .stuck_touch_timeout(q.stuck),
        .sec_tick(q.sec_tick),
        .touched(button_touched[i]),
        .touch_ev(touch_ev[i]),
        .release_ev(release_ev[i])
      );

      // Selected buttons: one button, or a group membership mask
      assign code = q.maps[i*4 +: 4];
      always_comb begin
        sel = 8'h00;
        if (code[3] == 1'b0) begin
          sel[code[2:0]] = 1'b1;
        end else if (code == `TBEL_CODE_GROUP0) begin
          sel = q.grp0;
        end else if (code == `TBEL_CODE_GROUP1) begin
          sel = q.grp1;
        end
      end
      assign any_on = |(touch_ev & sel);
      assign any_off = |(release_ev & sel);
      // A touch in a group beats a release of another member in the same cycle
      assign led_nx[i] = any_on ? 1'b1 : (any_off ? 1'b0 : q.led[i]);
    end
  endgenerate

  // ****************************************************************
  // Compensation triggers
  // ****************************************************************
  // Count of sensors at or over the suspend level in this sample
  always_comb begin
    hit_count = 4'h0;
    for (int k = 0; k < 8; k++) begin
      hit_count = hit_count + 4'(avg_hit[k]);
    end
  end
  assign three_fire = sample_valid && (hit_count >= `TBEL_COMP_SENSORS);
  // Saturating count; a clean sample starts it over
  assign neg_cnt_nx = (|neg_hit) ? ((q.neg_cnt == 8'hFF) ? q.neg_cnt : q.neg_cnt + 8'h01) : 8'h00;
  assign neg_fire = sample_valid && (|neg_hit) && (neg_cnt_nx >= q.neg_max);

  // ****************************************************************
  // Wake sequence helpers
  // ****************************************************************
  // Lowest touched button wins when several touch in one sample
  always_comb begin
    first_touch = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (touch_ev[k]) begin
        first_touch = 3'(k);
      end
    end
  end
  assign want_key = q.keys[q.wake_idx*4 +: 4];
  // Reserved codes have bit 3 set and so can never match
  assign key_match = (want_key == {1'b0, first_touch});
  assign final_key = (q.wake_idx + 3'h1) == q.wake_len;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    // Two-flop synchroniser for the asynchronous wake pin
    d.wake_pin_s1 = general_input_wake;
    d.wake_pin_s2 = q.wake_pin_s1;
    // One-second tick for the stuck timers
    d.sec_tick = 1'b0;
    if (q.sec_cnt == SEC_LAST) begin
      d.sec_cnt = 28'h000_0000;
      d.sec_tick = 1'b1;
    end else begin
      d.sec_cnt = q.sec_cnt + 28'h000_0001;
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `TBEL_OFF_AVG_THR: d.avg_thr = reg_wdata;
        `TBEL_OFF_NEG_THR: d.neg_thr = reg_wdata;
        `TBEL_OFF_NEG_MAX: d.neg_max = reg_wdata;
        `TBEL_OFF_HYST: d.hyst = reg_wdata;
        `TBEL_OFF_STUCK: d.stuck = reg_wdata;
        `TBEL_OFF_WAKE_LEN: d.wake_len = reg_wdata[`TBEL_WAKE_LEN_MSB:0];
        `TBEL_OFF_KEYS_45: d.keys[23:16] = reg_wdata;
        `TBEL_OFF_KEYS_23: d.keys[15:8] = reg_wdata;
        `TBEL_OFF_KEYS_01: d.keys[7:0] = reg_wdata;
        `TBEL_OFF_MAP_76: d.maps[31:24] = reg_wdata;
        `TBEL_OFF_MAP_54: d.maps[23:16] = reg_wdata;
        `TBEL_OFF_MAP_32: d.maps[15:8] = reg_wdata;
        `TBEL_OFF_MAP_10: d.maps[7:0] = reg_wdata;
        `TBEL_OFF_GRP0: d.grp0 = reg_wdata;
        `TBEL_OFF_GRP1: d.grp1 = reg_wdata;
        default: begin
        end
      endcase
    end
    // Read data one cycle after the address; unmapped and reserved bits read zero
    case (reg_addr)
      `TBEL_OFF_AVG_THR: d.rd = q.avg_thr;
      `TBEL_OFF_NEG_THR: d.rd = q.neg_thr;
      `TBEL_OFF_NEG_MAX: d.rd = q.neg_max;
      `TBEL_OFF_HYST: d.rd = q.hyst;
      `TBEL_OFF_STUCK: d.rd = q.stuck;
      `TBEL_OFF_WAKE_LEN: d.rd = {5'h00, q.wake_len};
      `TBEL_OFF_KEYS_45: d.rd = q.keys[23:16];
      `TBEL_OFF_KEYS_23: d.rd = q.keys[15:8];
      `TBEL_OFF_KEYS_01: d.rd = q.keys[7:0];
      `TBEL_OFF_MAP_76: d.rd = q.maps[31:24];
      `TBEL_OFF_MAP_54: d.rd = q.maps[23:16];
      `TBEL_OFF_MAP_32: d.rd = q.maps[15:8];
      `TBEL_OFF_MAP_10: d.rd = q.maps[7:0];
      `TBEL_OFF_GRP0: d.rd = q.grp0;
      `TBEL_OFF_GRP1: d.rd = q.grp1;
      default: d.rd = 8'h00;
    endcase
    // Averaging suspend flags follow each sample
    if (sample_valid) begin
      d.avg_susp = avg_hit;
      d.neg_cnt = neg_cnt_nx;
    end
    // Compensation: one request at a time, held until the new baselines arrive
    if (q.comp_req) begin
      if (comp_done) begin
        d.comp_req = 1'b0;
        d.neg_cnt = 8'h00;
      end
    end else if (three_fire || neg_fire) begin
      d.comp_req = 1'b1;
    end
    // Auto-lit outputs
    d.led = led_nx;
    // Doze entry and wake tracking
    if (!q.doze) begin
      if (doze_enter) begin
        d.doze = 1'b1;
        d.wake_idx = 3'h0;
        d.wake_held = 1'b0;
      end
    end else if (host_wake_cmd || q.wake_pin_s2) begin
      d.doze = 1'b0;
      d.wake_idx = 3'h0;
      d.wake_held = 1'b0;
    end else if (q.wake_len == `TBEL_WAKE_ANY) begin
      if (|(touch_ev | release_ev)) begin
        d.doze = 1'b0;
      end
    end else if (q.wake_len != `TBEL_WAKE_NONE) begin
      if (q.wake_held) begin
        // Only the release of the held key moves the tracker on
        if (release_ev[q.wake_btn]) begin
          d.wake_held = 1'b0;
          if (final_key) begin
            d.doze = 1'b0;
            d.wake_idx = 3'h0;
          end else begin
            d.wake_idx = q.wake_idx + 3'h1;
          end
        end
      end else if (|touch_ev) begin
        if (key_match) begin
          d.wake_held = 1'b1;
          d.wake_btn = first_touch;
        end else begin
          d.wake_idx = 3'h0;
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.avg_thr <= `TBEL_RST_AVG_THR;
      q.neg_thr <= `TBEL_RST_NEG_THR;
      q.neg_max <= `TBEL_RST_NEG_MAX;
      q.hyst <= `TBEL_RST_HYST;
      q.stuck <= `TBEL_RST_STUCK;
      q.wake_len <= `TBEL_RST_WAKE_LEN;
      q.grp0 <= `TBEL_RST_BYTE;
      q.grp1 <= `TBEL_RST_BYTE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = q.rd;
  assign avg_suspend = q.avg_susp;
  assign comp_req = q.comp_req;
  assign doze = q.doze;
  assign auto_lit_output = q.led;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_avg_flag;
    (sample_valid && avg_hit[0]) |=> avg_suspend[0];
  endproperty
  a_avg_flag : assert property (p_avg_flag) else $error("suspend flag missing");

  property p_three;
    (!comp_req && sample_valid && hit_count >= 4'h3) |=> comp_req;
  endproperty
  a_three : assert property (p_three) else $error("three sensors did not compensate");

  property p_neg_max;
    (!comp_req && sample_valid && |neg_hit && q.neg_max == 8'h01) |=> comp_req;
  endproperty
  a_neg_max : assert property (p_neg_max) else $error("negative count did not compensate");

  property p_comp_hold;
    (comp_req && !comp_done) |=> comp_req;
  endproperty
  a_comp_hold : assert property (p_comp_hold) else $error("request dropped early");

  property p_neg_clear;
    (sample_valid && !(|neg_hit)) |=> (q.neg_cnt == 8'h00);
  endproperty
  a_neg_clear : assert property (p_neg_clear) else $error("negative count kept");

  property p_len_none;
    (doze && q.wake_len == 3'h7 && !host_wake_cmd && !q.wake_pin_s2) |=> doze;
  endproperty
  a_len_none : assert property (p_len_none) else $error("sensor woke locked doze");

  property p_led_on;
    (q.maps[3:0] == 4'h0 && touch_ev[0]) |=> auto_lit_output[0];
  endproperty
  a_led_on : assert property (p_led_on) else $error("output not lit on touch");

  property p_wake_last;
    (doze && q.wake_len inside {[3'h1:3'h6]} && q.wake_held && release_ev[q.wake_btn] && final_key)
      |=> (!doze && q.wake_idx == 3'h0);
  endproperty
  a_wake_last : assert property (p_wake_last) else $error("final key did not wake");

  property p_wrong_key;
    (doze && q.wake_len inside {[3'h1:3'h6]} && !host_wake_cmd && !q.wake_pin_s2 && !q.wake_held
      && |touch_ev && !key_match) |=> (q.wake_idx == 3'h0 && !q.wake_held);
  endproperty
  a_wrong_key : assert property (p_wrong_key) else $error("wrong key kept progress");

  c_comp : cover property (!comp_req ##1 comp_req);
  c_wake : cover property (doze && q.wake_len == 3'h2 ##1 !doze);
  c_group : cover property (q.maps[3:0] == 4'hC && touch_ev != 8'h00 ##1 auto_lit_output[0]);
endmodule : tbel_core
`default_nettype wire

// ### pkg/tbel_defines.svh
// Register offsets, reset values, field codes and timing figures of the touch event block
`ifndef TBEL_DEFINES_SVH
`define TBEL_DEFINES_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TBEL_OFF_AVG_THR 8'h22
`define TBEL_OFF_NEG_THR 8'h23
`define TBEL_OFF_NEG_MAX 8'h24
`define TBEL_OFF_HYST 8'h25
`define TBEL_OFF_STUCK 8'h26
`define TBEL_OFF_WAKE_LEN 8'h33
`define TBEL_OFF_KEYS_45 8'h34
`define TBEL_OFF_KEYS_23 8'h35
`define TBEL_OFF_KEYS_01 8'h36
`define TBEL_OFF_MAP_76 8'h37
`define TBEL_OFF_MAP_54 8'h38
`define TBEL_OFF_MAP_32 8'h39
`define TBEL_OFF_MAP_10 8'h3A
`define TBEL_OFF_GRP0 8'h3C
`define TBEL_OFF_GRP1 8'h3E
// ****************************************************************
// Reset values
// ****************************************************************
`define TBEL_RST_AVG_THR 8'h50
`define TBEL_RST_NEG_THR 8'h50
`define TBEL_RST_NEG_MAX 8'h01
`define TBEL_RST_HYST 8'h0A
`define TBEL_RST_STUCK 8'h00
`define TBEL_RST_WAKE_LEN 3'h0
`define TBEL_RST_BYTE 8'h00
// ****************************************************************
// Field positions and codes
// ****************************************************************
`define TBEL_WAKE_LEN_MSB 2
`define TBEL_WAKE_ANY 3'h0
`define TBEL_WAKE_NONE 3'h7
`define TBEL_CODE_GROUP0 4'hC
`define TBEL_CODE_GROUP1 4'hD
`define TBEL_COMP_SENSORS 4'h3
`define TBEL_HYST_DIVISOR 18'h0_0064
// ****************************************************************
// Timing
// ****************************************************************
`define TBEL_SECOND_NS 1_000_000_000
`define TBEL_CLOCK_NS 4
`endif

// ### pkg/tbel_pkg.sv
// Types shared by the touch event block
`default_nettype none
package tbel_pkg;
  // Per-button decision state, one-hot
  typedef enum logic [2:0] {
    tbel_idle = 3'h1,
    tbel_touched = 3'h2,
    tbel_stuck = 3'h4
  } tbel_btn_state_t;

  // All state of one button decision
  typedef struct packed {
    tbel_btn_state_t state;
    logic [7:0] secs;
    logic touch_ev;
    logic release_ev;
  } tbel_btn_reg_t;

  // All state of the event core
  typedef struct packed {
    logic [7:0] avg_thr;
    logic [7:0] neg_thr;
    logic [7:0] neg_max;
    logic [7:0] hyst;
    logic [7:0] stuck;
    logic [2:0] wake_len;
    logic [23:0] keys;
    logic [31:0] maps;
    logic [7:0] grp0;
    logic [7:0] grp1;
    logic [7:0] rd;
    logic [7:0] avg_susp;
    logic [7:0] neg_cnt;
    logic comp_req;
    logic doze;
    logic [2:0] wake_idx;
    logic wake_held;
    logic [2:0] wake_btn;
    logic [7:0] led;
    logic [27:0] sec_cnt;
    logic sec_tick;
    logic wake_pin_s1;
    logic wake_pin_s2;
  } tbel_core_reg_t;
endpackage : tbel_pkg
`default_nettype wire

// ### rtl/tbel_btn.sv
// Touch, release and stuck-touch decision for one button
`default_nettype none
`include "tbel_defines.svh"
module tbel_btn #(
  parameter int TW = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic signed [TW-1:0] ticks,
  input wire logic [9:0] capacitance_threshold,
  input wire logic [7:0] touch_hysteresis_percent,
  input wire logic [7:0] stuck_touch_timeout,
  input wire logic sec_tick,
  output logic touched,
  output logic touch_ev,
  output logic release_ev
);
  logic [17:0] hyst_prod;
  logic [17:0] hyst_delta;
  logic signed [19:0] tick_x;
  logic signed [19:0] touch_lvl;
  logic signed [19:0] release_lvl;
  logic over_touch;
  logic under_release;
  logic timed_out;
  tbel_pkg::tbel_btn_reg_t q;
  tbel_pkg::tbel_btn_reg_t d;

  generate
    if (TW < 2 || TW > 19) begin : g_bad_tw
      $error("tick width must be 2 to 19");
    end
  endgenerate

  // ****************************************************************
  // Hysteresis levels
  // ****************************************************************
  // Share of the threshold, in percent, added for touch and removed for release
  assign hyst_prod = 18'(capacitance_threshold) * 18'(touch_hysteresis_percent);
  assign hyst_delta = hyst_prod / `TBEL_HYST_DIVISOR;
  assign tick_x = 20'(ticks);
  assign touch_lvl = $signed(20'(capacitance_threshold)) + $signed(20'(hyst_delta));
  assign release_lvl = $signed(20'(capacitance_threshold)) - $signed(20'(hyst_delta));
  assign over_touch = tick_x > touch_lvl;
  assign under_release = tick_x < release_lvl;
  // Zero timeout keeps the timer out of the decision altogether
  assign timed_out = (stuck_touch_timeout != 8'h00) && (q.secs >= stuck_touch_timeout);

  // ****************************************************************
  // Decision
  // ****************************************************************
  // Timeout is checked before the sample so a forced release is never missed
  always_comb begin
    d = q;
    d.touch_ev = 1'b0;
    d.release_ev = 1'b0;
    unique case (q.state)
      tbel_pkg::tbel_idle: begin
        if (sample_valid && over_touch) begin
          d.state = tbel_pkg::tbel_touched;
          d.secs = 8'h00;
          d.touch_ev = 1'b1;
        end
      end
      tbel_pkg::tbel_touched: begin
        if (timed_out) begin
          d.state = tbel_pkg::tbel_stuck;
          d.release_ev = 1'b1;
        end else if (sample_valid && under_release) begin
          d.state = tbel_pkg::tbel_idle;
          d.release_ev = 1'b1;
        end else if (sec_tick && q.secs != 8'hFF) begin
          d.secs = q.secs + 8'h01;
        end
      end
      tbel_pkg::tbel_stuck: begin
        // Finger must really leave before a new touch is taken
        if (sample_valid && under_release) begin
          d.state = tbel_pkg::tbel_idle;
        end
      end
      default: begin
        d.state = tbel_pkg::tbel_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '{state: tbel_pkg::tbel_idle, secs: 8'h00, touch_ev: 1'b0, release_ev: 1'b0};
    end else begin
      q <= d;
    end
  end

  // One-hot state: the touched code is bit 1, so the output is the flop itself
  assign touched = q.state[1];
  assign touch_ev = q.touch_ev;
  assign release_ev = q.release_ev;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_touch_on;
    (q.state == tbel_pkg::tbel_idle && sample_valid && over_touch) |=> (touched && touch_ev);
  endproperty
  a_touch_on : assert property (p_touch_on) else $error("touch not taken");

  property p_release;
    (touched && !timed_out && sample_valid && under_release) |=> (!touched && release_ev);
  endproperty
  a_release : assert property (p_release) else $error("release not taken");

  property p_stuck_quiet;
    (q.state == tbel_pkg::tbel_stuck) |=> !touch_ev;
  endproperty
  a_stuck_quiet : assert property (p_stuck_quiet) else $error("touch while stuck");

  property p_timer_off;
    (stuck_touch_timeout == 8'h00 && touched && !(sample_valid && under_release)) |=> touched;
  endproperty
  a_timer_off : assert property (p_timer_off) else $error("zero timeout released");
endmodule : tbel_btn
`default_nettype wire

// ### testbench/tbel_fe.sv
// Behavioural front end model: scan strobe, tick vector and compensation answer
`default_nettype none
module tbel_fe #(
  parameter int DLY = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0][15:0] tk,
  input wire logic comp_req,
  output logic sample_valid,
  output logic [7:0][15:0] ticks,
  output logic comp_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Ticks change only at a scan; the baseline answer is slow on purpose
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_valid <= 1'h0;
      ticks <= '0;
      comp_done <= 1'h0;
      cnt <= 0;
    end else begin
      sample_valid <= go;
      ticks <= go ? tk : ticks;
      cnt <= (comp_req && !comp_done) ? cnt + 1 : 0;
      comp_done <= comp_req && cnt == DLY;
    end
  end
endmodule // tbel_fe
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the touch event core
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, go = 0, sv, cd, cr, dz, de = 0, gw = 0, hw = 0, wr_q = 0;
  logic [7:0][9:0] cth = {8{10'h064}};
  logic [7:0] ad = 8'h00, wd = 8'h00, rd_v, sus, tch, led;
  logic [7:0][15:0] tk = '0, tks;
  int error_cnt = 0, n_tests = 0;
  always #2 clock = ~clock;
  tbel_fe fe_u (.clock(clock), .rst(rst), .go(go), .tk(tk), .comp_req(cr), .sample_valid(sv),
    .ticks(tks), .comp_done(cd));
  tbel_core #(.TW(16), .CYCLES_PER_SECOND(16)) dut_u (.clock(clock), .rst(rst), .sample_valid(sv),
    .ticks(tks), .capacitance_threshold(cth), .comp_done(cd), .doze_enter(de),
    .general_input_wake(gw), .host_wake_cmd(hw), .reg_wr(wr_q), .reg_addr(ad), .reg_wdata(wd),
    .reg_rdata(rd_v), .avg_suspend(sus), .comp_req(cr), .doze(dz), .button_touched(tch),
    .auto_lit_output(led));
  task automatic test_done;
    $display("Mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Writes hold the strobe one cycle and leave a gap so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_q = 1;
    ad = a;
    wd = d;
    cyc(1);
    wr_q = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ad = a;
    cyc(2);
    chk("reg_rdata", e, rd_v);
  endtask
  // One scan: sensors in the mask see value v, the rest sit at zero
  task automatic samp(input logic [7:0] m, input logic [15:0] v);
    for (int i = 0; i < 8; i++) tk[i] = m[i] ? v : 16'h0000;
    go = 1;
    cyc(1);
    go = 0;
    cyc(4);
  endtask
  task automatic sleep;
    de = 1;
    cyc(1);
    de = 0;
    cyc(1);
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 40 && cr !== 1'h0; k++) cyc(1);
    if (cr !== 1'h0) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic t_regs;
    rd(8'h22, 8'h50);
    rd(8'h23, 8'h50);
    rd(8'h24, 8'h01);
    rd(8'h25, 8'h0A);
    rd(8'h26, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h07);
    wr(8'h39, 8'hCD);
    rd(8'h39, 8'hCD);
    wr(8'h39, 8'h00);
  endtask
  task automatic t_touch;
    samp(8'h01, 16'h006E);
    chk("touched", 8'h00, tch);
    samp(8'h01, 16'h006F);
    chk("leds", 8'hFF, led);
    samp(8'h01, 16'h005A);
    chk("touched", 8'h01, tch);
    samp(8'h01, 16'h0059);
    chk("leds", 8'h00, led);
    // Threshold is per button: a higher one moves both levels
    cth[0] = 10'h0C8;
    samp(8'h01, 16'h00DC);
    chk("touched", 8'h00, tch);
    samp(8'h01, 16'h00DD);
    chk("touched", 8'h01, tch);
    samp(8'h01, 16'h00B4);
    chk("touched", 8'h01, tch);
    samp(8'h00, 16'h0000);
    cth[0] = 10'h064;
    wr(8'h3A, 8'hDC);
    wr(8'h3C, 8'h02);
    wr(8'h3E, 8'h04);
    samp(8'h02, 16'h0100);
    chk("leds", 8'h01, led);
    samp(8'h06, 16'h0100);
    chk("leds", 8'h03, led);
    samp(8'h00, 16'h0000);
    // Reserved map code: that output keeps its level
    wr(8'h3A, 8'h08);
    samp(8'h01, 16'h0100);
    chk("leds", 8'hFE, led);
    samp(8'h00, 16'h0000);
    wr(8'h3A, 8'h00);
  endtask
  task automatic t_comp;
    wr(8'h24, 8'h01);
    samp(8'h03, 16'h0140);
    chk("comp_req", 8'h00, {7'h00, cr});
    samp(8'h07, 16'h0140);
    chk("suspend", 8'h07, sus);
    chk("comp_req", 8'h01, {7'h00, cr});
    wait_idle();
    samp(8'h01, 16'hFEC0);
    chk("comp_req", 8'h00, {7'h00, cr});
    samp(8'h01, 16'hFEBF);
    chk("comp_req", 8'h01, {7'h00, cr});
    wait_idle();
    samp(8'h00, 16'h0000);
  endtask
  task automatic t_stuck;
    wr(8'h26, 8'h01);
    samp(8'h01, 16'h0100);
    cyc(40);
    chk("touched", 8'h00, tch);
    samp(8'h01, 16'h0100);
    chk("touched", 8'h00, tch);
    samp(8'h00, 16'h0000);
    wr(8'h26, 8'h00);
    samp(8'h01, 16'h0100);
    cyc(40);
    chk("touched", 8'h01, tch);
    samp(8'h00, 16'h0000);
  endtask
  task automatic t_wake;
    wr(8'h33, 8'h02);
    wr(8'h36, 8'h52);
    sleep();
    samp(8'h04, 16'h0100);
    samp(8'h00, 16'h0000);
    samp(8'h08, 16'h0100);
    samp(8'h00, 16'h0000);
    samp(8'h20, 16'h0100);
    samp(8'h00, 16'h0000);
    chk("doze", 8'h01, {7'h00, dz});
    samp(8'h04, 16'h0100);
    samp(8'h0C, 16'h0100);
    samp(8'h04, 16'h0100);
    samp(8'h00, 16'h0000);
    samp(8'h20, 16'h0100);
    chk("doze", 8'h01, {7'h00, dz});
    samp(8'h00, 16'h0000);
    chk("doze", 8'h00, {7'h00, dz});
    wr(8'h33, 8'h07);
    sleep();
    samp(8'h01, 16'h0100);
    samp(8'h00, 16'h0000);
    chk("doze", 8'h01, {7'h00, dz});
    gw = 1;
    cyc(6);
    gw = 0;
    chk("doze", 8'h00, {7'h00, dz});
    // Let the synchroniser drain so the old pin level cannot end the next doze
    cyc(3);
    sleep();
    chk("doze", 8'h01, {7'h00, dz});
    hw = 1;
    cyc(1);
    hw = 0;
    cyc(1);
    chk("doze", 8'h00, {7'h00, dz});
    // Reserved key code: no button can ever satisfy it
    wr(8'h33, 8'h01);
    wr(8'h36, 8'h08);
    sleep();
    samp(8'h01, 16'h0100);
    samp(8'h00, 16'h0000);
    chk("doze", 8'h01, {7'h00, dz});
    // Length zero: any event ends the doze already in progress
    wr(8'h33, 8'h00);
    samp(8'h01, 16'h0100);
    chk("doze", 8'h00, {7'h00, dz});
    samp(8'h00, 16'h0000);
  endtask
  // Main sequence
  initial begin
    cyc(6);
    rst = 0;
    cyc(1);
    t_regs();
    t_touch();
    t_comp();
    t_stuck();
    t_wake();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
